// File: hdl/dac_serial_write_port.sv
// Serial write port of a 12-bit string DAC
// Functional notes
// - Sixteen-bit input shift register from data pin
// - Sample data on falling serial clock edge
// - Low frame select enables shifting
// - Sixteenth falling edge loads received word
// - Early select rise aborts, no update
// - Code is unsigned straight binary 0..4095
// - Code selects exactly one string tap
// - Word: two ignored, two mode, twelve data
// - Mode bits pick normal or power-down load
// - Power-on clears DAC register to zero
`timescale 1ns/100ps
`default_nettype none
module dac_serial_write_port #(
  parameter int WORD_W = dac_write_pkg::WORD_BITS,
  parameter int CODE_W = dac_write_pkg::CODE_BITS
) (
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Serial link pins
  input wire logic i_frame_sel_n,
  input wire logic i_sclk,
  input wire logic i_sdata,
  // DAC state
  output logic [CODE_W-1:0] o_dac_code,
  output logic [1:0] o_power_mode,
  output logic o_powered_down,
  output logic o_update,
  output logic [(1<<CODE_W)-1:0] o_tap_sel
);
  initial begin
    if (WORD_W != dac_write_pkg::WORD_BITS || CODE_W != dac_write_pkg::CODE_BITS) begin
      $error("dac_serial_write_port: word layout is fixed at 16/12 bits");
    end
    if ((1 << dac_write_pkg::CNT_BITS) <= WORD_W) begin
      $error("dac_serial_write_port: bit counter too narrow for the word");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} frame_state_e;

  // Two-flop synchronisers, then one history flop for edge detection
  logic [2:0] sel_sync_r;
  logic [2:0] clk_sync_r;
  logic [1:0] dat_sync_r;
  // Select history resets high, its idle level
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_sync_r <= 3'h7;
    end else begin
      sel_sync_r <= {sel_sync_r[1:0], i_frame_sel_n};
    end
  end

  // Serial clock history; only falls are used
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_sync_r <= 3'h0;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], i_sclk};
    end
  end

  // Serial data, two flops
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dat_sync_r <= 2'h0;
    end else begin
      dat_sync_r <= {dat_sync_r[0], i_sdata};
    end
  end

  wire logic sel_n;
  wire logic sel_was_low;
  wire logic sclk_fall;
  wire logic din;
  assign sel_n = sel_sync_r[1];
  // A fall seen together with the select rise came while select was still low
  assign sel_was_low = ~sel_sync_r[2];
  assign sclk_fall = ~clk_sync_r[1] & clk_sync_r[2];
  // Data was sampled on the same core edge that first saw the serial clock low
  assign din = dat_sync_r[1];

  frame_state_e state_r;
  frame_state_e state_nxt;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;
  logic [dac_write_pkg::CNT_BITS-1:0] cnt_r;
  logic [dac_write_pkg::CNT_BITS-1:0] cnt_nxt;
  logic load;

  wire logic take_bit;
  wire logic last_bit;
  wire logic abort_frame;
  assign take_bit = (state_r == ST_SHIFT) && sel_was_low && sclk_fall;
  assign last_bit = take_bit && (cnt_r == dac_write_pkg::CNT_FULL - 5'h01);
  assign abort_frame = (state_r == ST_SHIFT) && sel_n && !last_bit;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    load = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (!sel_n) begin
          state_nxt = ST_SHIFT;
          cnt_nxt = '0;
          shift_nxt = '0;
        end
      end
      ST_SHIFT: begin
        if (abort_frame) begin
          state_nxt = ST_IDLE;
          cnt_nxt = '0;
          shift_nxt = '0;
        end else if (take_bit) begin
          shift_nxt = {shift_r[WORD_W-2:0], din};
          cnt_nxt = cnt_r + 5'h01;
          if (last_bit) begin
            load = 1'b1;
            state_nxt = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (sel_n) begin
          state_nxt = ST_IDLE;
          cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Frame state
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shift register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // Bit counter
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Field extraction from the completed word
  wire logic [WORD_W-1:0] word_full;
  wire logic [1:0] mode_field;
  wire logic [CODE_W-1:0] code_field;
  wire logic mode_bit_high;
  wire logic mode_bit_low;
  assign word_full = {shift_r[WORD_W-2:0], din};
  assign mode_bit_high = word_full[dac_write_pkg::MODE_HI_POS];
  assign mode_bit_low = word_full[dac_write_pkg::MODE_LO_POS];
  assign mode_field = {mode_bit_high, mode_bit_low};
  assign code_field = word_full[dac_write_pkg::CODE_MSB_POS:0];

  // Power-down keeps the code; only normal mode writes it
  wire logic code_write;
  wire logic powered_down_nxt;
  assign code_write = load && (mode_field == dac_write_pkg::MODE_NORMAL);
  assign powered_down_nxt = (mode_field != dac_write_pkg::MODE_NORMAL);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_update <= 1'b0;
    end else begin
      o_update <= load;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dac_code <= dac_write_pkg::CODE_RESET;
    end else if (code_write) begin
      o_dac_code <= code_field;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_power_mode <= dac_write_pkg::MODE_RESET;
      o_powered_down <= 1'b0;
    end else if (load) begin
      o_power_mode <= mode_field;
      o_powered_down <= powered_down_nxt;
    end
  end

  // Registered one-hot tap select
  tap_decoder #(
    .CODE_W(CODE_W)
  ) tap_decoder_i (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_code(o_dac_code),
    .o_tap(o_tap_sel)
  );
endmodule
`default_nettype wire

// File: hdl/dac_write_pkg.sv
// Constants for the serial DAC write port
package dac_write_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int MODE_BITS = 2;
  localparam int MODE_HI_POS = 13;
  localparam int MODE_LO_POS = 12;
  localparam int CODE_MSB_POS = 11;
  localparam int TAPS = 4096;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PD_1K = 2'h1;
  localparam logic [1:0] MODE_PD_100K = 2'h2;
  localparam logic [1:0] MODE_PD_HIZ = 2'h3;
endpackage

// File: hdl/tap_decoder.sv
// One-hot resistor-string tap decoder with registered output
`timescale 1ns/100ps
`default_nettype none
module tap_decoder #(
  parameter int CODE_W = 12
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Code in, tap select out
  input wire logic [CODE_W-1:0] i_code,
  output logic [(1<<CODE_W)-1:0] o_tap
);
  initial begin
    if (CODE_W < 1 || CODE_W > 16) begin
      $error("tap_decoder: CODE_W out of range");
    end
  end
  wire logic [(1<<CODE_W)-1:0] tap_nxt;
  assign tap_nxt = {{((1<<CODE_W)-1){1'b0}}, 1'b1} << i_code;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tap <= {{((1<<CODE_W)-1){1'b0}}, 1'b1};
    end else begin
      o_tap <= tap_nxt;
    end
  end
endmodule
`default_nettype wire

// File: verif/dac_serial_write_port_sva.sv
// Assertion checker for the serial DAC write port
`timescale 1ns/100ps
`default_nettype none
module dac_serial_write_port_sva #(
  parameter int CODE_W = 12
) (
  // Clock, reset and frame select
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_frame_sel_n,
  // DAC state
  input wire logic [CODE_W-1:0] o_dac_code,
  input wire logic [1:0] o_power_mode,
  input wire logic o_powered_down,
  input wire logic o_update,
  input wire logic [(1<<CODE_W)-1:0] o_tap_sel
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_load; o_update; endsequence
  sequence s_idle; i_frame_sel_n [*8]; endsequence
  property p_pulse; s_load |=> !o_update; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_code; $changed(o_dac_code) |-> s_load; endproperty
  a_code: assert property (p_code) else $error("code moved");
  property p_mode; $changed(o_power_mode) |-> s_load; endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_pd; o_powered_down == (o_power_mode != 2'h0); endproperty
  a_pd: assert property (p_pd) else $error("pd flag");
  property p_hot; $onehot(o_tap_sel); endproperty
  a_hot: assert property (p_hot) else $error("tap not one-hot");
  property p_tap; o_tap_sel[$past(o_dac_code)]; endproperty
  a_tap: assert property (p_tap) else $error("wrong tap");
  property p_keep; s_load ##0 (o_power_mode != 2'h0) |-> $stable(o_dac_code); endproperty
  a_keep: assert property (p_keep) else $error("code lost");
  property p_frame; s_idle |-> !o_update; endproperty
  a_frame: assert property (p_frame) else $error("update idle");
endmodule
bind dac_serial_write_port dac_serial_write_port_sva #(.CODE_W(CODE_W)) sva_i (.i_core_clk,
  .i_reset_n, .i_frame_sel_n, .o_dac_code, .o_power_mode, .o_powered_down, .o_update, .o_tap_sel);
`default_nettype wire

// File: verif/dac_serial_write_port_tb.sv
// Self-checking bench for the serial DAC write port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t mismatch", $time); end end
module dac_serial_write_port_tb;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  wire logic sel_n, sclk, sdata, o_powered_down, o_update;
  wire logic [11:0] o_dac_code;
  wire logic [1:0] o_power_mode;
  wire logic [4095:0] o_tap_sel;
  logic [11:0] exp_code = 12'h000;
  logic [1:0] exp_mode = 2'h0;
  logic [31:0] seed = 32'h783A;
  int mismatches = 0, compares = 0, cycles = 0, updates = 0, exp_upd = 0;
  logic [15:0] words [6] = '{16'hCFFF, 16'h1ABC, 16'h2123, 16'h3000, 16'h0800, 16'hFFFF};
  always #4 i_core_clk = ~i_core_clk;
  host_model host_i (.o_frame_sel_n(sel_n), .o_sclk(sclk), .o_sdata(sdata));
  dac_serial_write_port dac_serial_write_port_i (.i_core_clk, .i_reset_n,
    .i_frame_sel_n(sel_n), .i_sclk(sclk), .i_sdata(sdata), .o_dac_code,
    .o_power_mode, .o_powered_down, .o_update, .o_tap_sel);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic void apply(input logic [15:0] w);
    exp_mode = w[13:12];
    if (w[13:12] === 2'h0) exp_code = w[11:0];
    exp_upd++;
  endfunction
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic frame(input logic [15:0] w, input int n);
    @(posedge i_core_clk) #1;
    host_i.send(w, n);
    if (n >= 16) apply(w);
    `CHK(o_dac_code, exp_code)
    `CHK(o_power_mode, exp_mode)
    `CHK(o_powered_down, exp_mode != 2'h0)
    `CHK(o_tap_sel[exp_code], 1'b1)
    `CHK(updates, exp_upd)
  endtask
  always @(posedge i_core_clk) begin
    cycles++;
    if (o_update === 1'b1) updates++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge i_core_clk);
    #1 i_reset_n = 1'b1;
    repeat (3) @(posedge i_core_clk);
    `CHK(o_dac_code, 12'h000)
    `CHK(o_tap_sel[0], 1'b1)
    foreach (words[k]) frame(words[k], 16);
    frame(16'h0555, 15);
    frame(16'h0A5A, 18);
    repeat (20) begin
      seed = xs(seed);
      frame(seed[15:0], seed[16] ? 16 : 1 + seed[20:17]);
    end
    summarize();
  end
endmodule
`default_nettype wire

// File: verif/host_model.sv
// Host serial master that sends frames to the DAC port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Serial link pins
  output var logic o_frame_sel_n,
  output var logic o_sclk,
  output var logic o_sdata
);
  initial begin
    o_frame_sel_n = 1'b1;
    o_sclk = 1'b1;
    o_sdata = 1'b0;
  end
  // Sends the n leading bits of w, wrapping back to w[15] after the 16th; fewer than 16 aborts the frame
  task automatic send(input logic [15:0] w, input int n);
    o_frame_sel_n = 1'b0;
    #40;
    for (int k = 15; k > 15 - n; k--) begin
      o_sdata = w[k & 15];
      #62.5 o_sclk = 1'b0;
      #62.5 o_sclk = 1'b1;
    end
    o_sdata = ~o_sdata;
    o_frame_sel_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire
